/* rtl/cfp_pkg.sv */
package cfp_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int CFP_ADDR_W = 22;
  localparam logic [21:0] CFP_CFG_ADDR = 22'h300002;
  localparam logic [21:0] CFP_PROT_ADDR = 22'h30000B;
  localparam logic [21:0] CFP_ID_BASE = 22'h200000;
  localparam int CFP_ID_COUNT = 8;
  localparam int CFP_ID_IDX_W = 3;
  localparam logic [21:0] CFP_EE_BASE = 22'h3F0000;
  localparam int CFP_EE_IDX_W = 10;

  // ----------------------------------------------------------------
  // Configuration byte layout and reset values
  // ----------------------------------------------------------------
  localparam int CFP_PWR_LSB = 5;
  localparam int CFP_TRIP_LSB = 3;
  localparam int CFP_UVEN_LSB = 1;
  localparam int CFP_STT_BIT = 0;
  localparam logic [6:0] CFP_CFG_RESET = 7'h7F;
  localparam logic [1:0] CFP_PWR_ZERO = 2'h3;

  // ----------------------------------------------------------------
  // Protection byte layout and reset value
  // ----------------------------------------------------------------
  localparam int CFP_RDP_BIT = 0;
  localparam int CFP_WRP_BIT = 1;
  localparam int CFP_CWP_BIT = 2;
  localparam logic [7:0] CFP_PROT_MASK = 8'h07;
  localparam logic [7:0] CFP_PROT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Trip voltages in millivolts
  // ----------------------------------------------------------------
  localparam logic [11:0] CFP_TRIP_MV_3 = 12'h708;
  localparam logic [11:0] CFP_TRIP_MV_2 = 12'h7D0;
  localparam logic [11:0] CFP_TRIP_MV_1 = 12'hA8C;
  localparam logic [11:0] CFP_TRIP_MV_0 = 12'hBB8;

  // ----------------------------------------------------------------
  // Programming link framing
  // ----------------------------------------------------------------
  localparam int CFP_CMD_BITS = 32;
  localparam int CFP_REPLY_BITS = 8;
  localparam logic [5:0] CFP_CMD_LAST = 6'h1F;
  localparam logic [5:0] CFP_REPLY_LAST = 6'h07;

  typedef enum logic [1:0] {
    UV_OFF = 2'b00,
    UV_SOFT = 2'b01,
    UV_HW_NOSLEEP = 2'b10,
    UV_HW = 2'b11
  } cfp_uv_mode_type;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_IDLE_A = 2'b10,
    OP_IDLE_B = 2'b11
  } cfp_op_type;

  typedef enum logic {
    LS_REPLY = 1'b0,
    LS_CMD = 1'b1
  } cfp_link_state_type;

  typedef struct packed {
    cfp_op_type op;
    logic [21:0] addr;
    logic [7:0] data;
  } cfp_frame_type;

  typedef struct packed {
    logic [1:0] pwr;
    logic [1:0] trip;
    cfp_uv_mode_type uv_mode;
    logic stt_n;
  } cfp_ctl_type;

endpackage : cfp_pkg

/* rtl/cfp_sync2.sv */
module cfp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Level in and out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : cfp_sync2

/* rtl/cfp_link.sv */
module cfp_link
  import cfp_pkg::*;
(
  // Link clock and reset
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  // Serial data line
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o,
  // Toward the system domain
  input wire logic [7:0] reply_i,
  output cfp_frame_type frame_o,
  output logic frame_tgl_o
);

  cfp_link_state_type state_q;
  logic [5:0] cnt_q;
  logic [31:0] shift_q;
  logic [7:0] out_q;

  // The first reply bit comes straight from the system-side holding
  // register, which settled during the idle gap before this frame.
  assign data_o = (cnt_q == 6'h00) ? reply_i[7] : out_q[7];
  assign data_oe_o = (state_q == LS_REPLY) & link_rst_n_i;

  always_ff @(posedge link_clk_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
    begin
      state_q <= LS_REPLY;
      cnt_q <= 6'h00;
      out_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        LS_REPLY:
        begin
          if (cnt_q == 6'h00)
            out_q <= {reply_i[6:0], 1'b0};
          else
            out_q <= {out_q[6:0], 1'b0};
          if (cnt_q == CFP_REPLY_LAST)
          begin
            state_q <= LS_CMD;
            cnt_q <= 6'h00;
          end
          else
            cnt_q <= cnt_q + 6'h01;
        end
        LS_CMD:
        begin
          if (cnt_q == CFP_CMD_LAST)
          begin
            state_q <= LS_REPLY;
            cnt_q <= 6'h00;
          end
          else
            cnt_q <= cnt_q + 6'h01;
        end
        default:
        begin
          state_q <= LS_REPLY;
          cnt_q <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
    begin
      shift_q <= 32'h00000000;
      frame_o <= '0;
      frame_tgl_o <= 1'b0;
    end
    else if (state_q == LS_CMD)
    begin
      shift_q <= {shift_q[30:0], data_i};
      if (cnt_q == CFP_CMD_LAST)
      begin
        frame_o <= cfp_frame_type'({shift_q[30:0], data_i});
        frame_tgl_o <= ~frame_tgl_o;
      end
    end
  end

endmodule : cfp_link

/* rtl/cfp_top.sv */
// Operation
// - Power field bits 6-5; 11 picks zero-power monitor, else high/medium/low.
// - Trip field bits 4-3 selects 1.8V, 2.0V, 2.7V or 3.0V.
// - Mode 11 enables undervoltage reset in hardware; software bit ignored.
// - Mode 10 enables it in hardware except during sleep; software ignored.
// - Mode 01 lets the software enable bit alone control the reset.
// - Mode 00 keeps the undervoltage reset off whatever software sets.
// - Bit 0 is active low; zero enables the startup timer.
// - Startup timer enable is independent of undervoltage reset settings.
// - Bit 7 of the configuration byte always reads zero.
// - Read protect blocks programmer reads and writes of data eeprom.
// - Write protect blocks eeprom writes from both processor and programmer.
// - The processor may always read the data eeprom.
// - Running code cannot change the configuration write-protect bit.
// - Only the serial programmer, or reset clearing it, may change the config write-protect bit.
// - Eight identification bytes up to 200007h, table readable and writable.
// - Identification bytes stay readable while code protection is active.
module cfp_top
  import cfp_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Serial programming link
  input wire logic pgm_clk_i,
  input wire logic pgm_mode_i,
  input wire logic pgm_data_i,
  output logic pgm_data_o,
  output logic pgm_data_oe_o,
  // Processor table access
  input wire logic [21:0] tbl_addr_i,
  input wire logic table_read_instr_i,
  input wire logic table_write_instr_i,
  input wire logic [7:0] tbl_wdata_i,
  output logic [7:0] tbl_rdata_o,
  output logic tbl_ack_o,
  // Processor data eeprom requests
  input wire logic cpu_ee_rd_i,
  input wire logic cpu_ee_wr_i,
  output logic cpu_ee_rd_o,
  output logic cpu_ee_wr_o,
  // Programmer data eeprom port
  input wire logic [7:0] ext_ee_rdata_i,
  output logic [9:0] ext_ee_addr_o,
  output logic [7:0] ext_ee_wdata_o,
  output logic ext_ee_rd_o,
  output logic ext_ee_wr_o,
  // Undervoltage and startup control
  input wire logic soft_undervoltage_enable_i,
  input wire logic sleep_i,
  output logic [1:0] monitor_power_level_o,
  output logic zero_power_undervoltage_monitor_o,
  output logic [1:0] trip_voltage_select_o,
  output logic [11:0] trip_voltage_mv_o,
  output logic undervoltage_reset_en_o,
  output logic startup_timer_en_o,
  // Protection status
  output logic eeprom_read_protect_o,
  output logic eeprom_write_protect_o,
  output logic config_write_protect_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [6:0] cfg_q = CFP_CFG_RESET;
  logic [7:0] prot_q;
  logic [7:0] id_q [CFP_ID_COUNT];
  cfp_ctl_type ctl_q;
  logic load_pend_q;
  logic [7:0] reply_q;
  logic ee_rd_pend_q;
  logic tgl_seen_q;

  logic pgm_mode_s;
  logic frame_tgl;
  logic frame_tgl_s;
  logic link_rst_n;
  cfp_frame_type frame;
  logic frame_evt;
  logic pgm_wr;
  logic pgm_rd;
  logic cpu_wr;
  logic rd_prot;
  logic wr_prot;
  logic cfg_prot;

  assign rd_prot = prot_q[CFP_RDP_BIT];
  assign wr_prot = prot_q[CFP_WRP_BIT];
  assign cfg_prot = prot_q[CFP_CWP_BIT];

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_id(input logic [21:0] a);
    is_id = (a[21:CFP_ID_IDX_W] == CFP_ID_BASE[21:CFP_ID_IDX_W]);
  endfunction : is_id

  function automatic logic is_ee(input logic [21:0] a);
    is_ee = (a[21:CFP_EE_IDX_W] == CFP_EE_BASE[21:CFP_EE_IDX_W]);
  endfunction : is_ee

  // Unmapped addresses read as zero.
  function automatic logic [7:0] rd_byte(input logic [21:0] a);
    rd_byte = 8'h00;
    if (a == CFP_CFG_ADDR)
      rd_byte = {1'b0, cfg_q};
    else if (a == CFP_PROT_ADDR)
      rd_byte = prot_q;
    else if (is_id(a))
      rd_byte = id_q[a[CFP_ID_IDX_W-1:0]];
  endfunction : rd_byte

  // ----------------------------------------------------------------
  // Programming link
  // ----------------------------------------------------------------
  // The link side is held in reset outside programming mode, so the
  // bit counter always starts a session aligned to a frame boundary.
  assign link_rst_n = reset_n_i & pgm_mode_i;

  cfp_link u_link (
    .link_clk_i(pgm_clk_i),
    .link_rst_n_i(link_rst_n),
    .data_i(pgm_data_i),
    .data_o(pgm_data_o),
    .data_oe_o(pgm_data_oe_o),
    .reply_i(reply_q),
    .frame_o(frame),
    .frame_tgl_o(frame_tgl)
  );

  cfp_sync2 #(
    .W(1)
  ) u_sync_mode (
    .clk_i(sys_clk_i),
    .rst_n_i(reset_n_i),
    .d_i(pgm_mode_i),
    .q_o(pgm_mode_s)
  );

  cfp_sync2 #(
    .W(1)
  ) u_sync_tgl (
    .clk_i(sys_clk_i),
    .rst_n_i(reset_n_i),
    .d_i(frame_tgl),
    .q_o(frame_tgl_s)
  );

  // The frame word stays still until the next frame ends, which is
  // many system cycles after the toggle is seen, so it is read here
  // without a synchroniser of its own.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tgl_seen_q <= 1'b0;
    else
      tgl_seen_q <= frame_tgl_s;
  end

  assign frame_evt = (frame_tgl_s ^ tgl_seen_q) & pgm_mode_s;
  assign pgm_wr = frame_evt & (frame.op == OP_WRITE);
  assign pgm_rd = frame_evt & (frame.op == OP_READ);
  assign cpu_wr = table_write_instr_i & ~pgm_wr;

  // ----------------------------------------------------------------
  // Configuration byte
  // ----------------------------------------------------------------
  // A programmer write takes priority over a processor write that
  // lands in the same cycle.
  // The byte models non-volatile cells and so ignores reset.
  always_ff @(posedge sys_clk_i)
  begin
    if (pgm_wr && frame.addr == CFP_CFG_ADDR)
      cfg_q <= frame.data[6:0];
    else if (cpu_wr && !cfg_prot && tbl_addr_i == CFP_CFG_ADDR)
      cfg_q <= tbl_wdata_i[6:0];
  end

  // ----------------------------------------------------------------
  // Protection byte
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prot_q <= CFP_PROT_RESET;
    else if (pgm_wr && frame.addr == CFP_PROT_ADDR)
      prot_q <= frame.data & CFP_PROT_MASK;
    else if (cpu_wr && !cfg_prot && tbl_addr_i == CFP_PROT_ADDR)
    begin
      prot_q[CFP_RDP_BIT] <= tbl_wdata_i[CFP_RDP_BIT];
      prot_q[CFP_WRP_BIT] <= tbl_wdata_i[CFP_WRP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Identification bytes
  // ----------------------------------------------------------------
  // Table and programmer access
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < CFP_ID_COUNT; i++)
        id_q[i] <= 8'h00;
    end
    else if (pgm_wr && is_id(frame.addr))
      id_q[frame.addr[CFP_ID_IDX_W-1:0]] <= frame.data;
    else if (cpu_wr && is_id(tbl_addr_i))
      id_q[tbl_addr_i[CFP_ID_IDX_W-1:0]] <= tbl_wdata_i;
  end

  // ----------------------------------------------------------------
  // Processor table answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tbl_rdata_o <= 8'h00;
      tbl_ack_o <= 1'b0;
    end
    else
    begin
      tbl_ack_o <= table_read_instr_i | table_write_instr_i;
      if (table_read_instr_i)
        tbl_rdata_o <= rd_byte(tbl_addr_i);
    end
  end

  // ----------------------------------------------------------------
  // Data eeprom gating
  // ----------------------------------------------------------------
  // Processor reads pass
  assign cpu_ee_rd_o = cpu_ee_rd_i;
  assign cpu_ee_wr_o = cpu_ee_wr_i & ~wr_prot;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ext_ee_addr_o <= 10'h000;
      ext_ee_wdata_o <= 8'h00;
      ext_ee_rd_o <= 1'b0;
      ext_ee_wr_o <= 1'b0;
    end
    else
    begin
      ext_ee_addr_o <= frame.addr[CFP_EE_IDX_W-1:0];
      ext_ee_wdata_o <= frame.data;
      ext_ee_rd_o <= pgm_rd & is_ee(frame.addr) & ~rd_prot;
      ext_ee_wr_o <= pgm_wr & is_ee(frame.addr) & ~rd_prot & ~wr_prot;
    end
  end

  // ----------------------------------------------------------------
  // Programmer read reply
  // ----------------------------------------------------------------
  // The reply is shifted out at the head of the next frame; a blocked
  // eeprom read answers zero so protected contents never leave.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reply_q <= 8'h00;
      ee_rd_pend_q <= 1'b0;
    end
    else
    begin
      ee_rd_pend_q <= ext_ee_rd_o;
      if (ee_rd_pend_q)
        reply_q <= ext_ee_rdata_i;
      else if (pgm_rd)
        reply_q <= rd_byte(frame.addr);
    end
  end

  // ----------------------------------------------------------------
  // Control latches
  // ----------------------------------------------------------------
  // Latch after reset
  // Changes to the configuration byte act only after the next reset,
  // so supply supervision never shifts under running code.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      load_pend_q <= 1'b1;
      ctl_q <= '0;
    end
    else if (load_pend_q)
    begin
      load_pend_q <= 1'b0;
      ctl_q.pwr <= cfg_q[CFP_PWR_LSB+:2];
      ctl_q.trip <= cfg_q[CFP_TRIP_LSB+:2];
      ctl_q.uv_mode <= cfp_uv_mode_type'(cfg_q[CFP_UVEN_LSB+:2]);
      ctl_q.stt_n <= cfg_q[CFP_STT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage and startup outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      undervoltage_reset_en_o <= 1'b0;
    else
    begin
      case (ctl_q.uv_mode)
        UV_HW: undervoltage_reset_en_o <= 1'b1;
        UV_HW_NOSLEEP: undervoltage_reset_en_o <= ~sleep_i;
        UV_SOFT: undervoltage_reset_en_o <= soft_undervoltage_enable_i;
        UV_OFF: undervoltage_reset_en_o <= 1'b0;
        default: undervoltage_reset_en_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      monitor_power_level_o <= 2'h0;
      zero_power_undervoltage_monitor_o <= 1'b0;
      trip_voltage_select_o <= 2'h0;
      trip_voltage_mv_o <= 12'h000;
      startup_timer_en_o <= 1'b0;
    end
    else
    begin
      monitor_power_level_o <= ctl_q.pwr;
      zero_power_undervoltage_monitor_o <= (ctl_q.pwr == CFP_PWR_ZERO);
      trip_voltage_select_o <= ctl_q.trip;
      case (ctl_q.trip)
        2'h3: trip_voltage_mv_o <= CFP_TRIP_MV_3;
        2'h2: trip_voltage_mv_o <= CFP_TRIP_MV_2;
        2'h1: trip_voltage_mv_o <= CFP_TRIP_MV_1;
        default: trip_voltage_mv_o <= CFP_TRIP_MV_0;
      endcase
      startup_timer_en_o <= ~ctl_q.stt_n;
    end
  end

  // ----------------------------------------------------------------
  // Protection status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      eeprom_read_protect_o <= 1'b0;
      eeprom_write_protect_o <= 1'b0;
      config_write_protect_o <= 1'b0;
    end
    else
    begin
      eeprom_read_protect_o <= rd_prot;
      eeprom_write_protect_o <= wr_prot;
      config_write_protect_o <= cfg_prot;
    end
  end

endmodule : cfp_top

/* bench/cfp_top_chk.sv */
module cfp_top_chk
  import cfp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Requests seen at the ports
  input wire logic pgm_mode_i,
  input wire logic [21:0] tbl_addr_i,
  input wire logic table_read_instr_i,
  input wire logic table_write_instr_i,
  input wire logic cpu_ee_rd_i,
  input wire logic cpu_ee_wr_i,
  // Answers of the design
  input wire logic [7:0] tbl_rdata_o,
  input wire logic tbl_ack_o,
  input wire logic cpu_ee_rd_o,
  input wire logic cpu_ee_wr_o,
  input wire logic ext_ee_rd_o,
  input wire logic ext_ee_wr_o,
  input wire logic [1:0] monitor_power_level_o,
  input wire logic zero_power_undervoltage_monitor_o,
  input wire logic [1:0] trip_voltage_select_o,
  input wire logic [11:0] trip_voltage_mv_o,
  input wire logic startup_timer_en_o,
  input wire logic eeprom_read_protect_o,
  input wire logic eeprom_write_protect_o,
  input wire logic config_write_protect_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // Checks
  // --------
  localparam logic [11:0] MV [4] = '{CFP_TRIP_MV_0, CFP_TRIP_MV_1,
    CFP_TRIP_MV_2, CFP_TRIP_MV_3};
  logic [1:0] up_q;

  // Derived outputs settle two edges after reset, so checks wait for three.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_tbl_req;
    table_read_instr_i || table_write_instr_i;
  endsequence
  sequence s_cfg_rd;
    table_read_instr_i && tbl_addr_i == CFP_CFG_ADDR;
  endsequence

  AST_ZERO_PWR: assert property (
    up_q == 2'h3 |-> zero_power_undervoltage_monitor_o ==
      (monitor_power_level_o == CFP_PWR_ZERO))
    else $error("zero-power monitor select wrong");
  AST_TRIP_MV: assert property (
    up_q == 2'h3 |-> trip_voltage_mv_o == MV[trip_voltage_select_o])
    else $error("trip voltage value wrong");
  AST_CFG_HOLD: assert property (
    up_q == 2'h3 |-> $stable({monitor_power_level_o,
      trip_voltage_select_o, startup_timer_en_o}))
    else $error("latched setting changed outside reset");
  AST_CPU_WR: assert property (
    ##1 $past(cpu_ee_wr_o) ==
      ($past(cpu_ee_wr_i) && !eeprom_write_protect_o))
    else $error("processor eeprom write gate wrong");
  AST_CPU_RD: assert property (
    cpu_ee_rd_o == cpu_ee_rd_i)
    else $error("processor eeprom read blocked");
  AST_EXT_RD: assert property (
    ext_ee_rd_o |-> !eeprom_read_protect_o)
    else $error("programmer eeprom read not blocked");
  AST_EXT_WR: assert property (
    ext_ee_wr_o |-> !(eeprom_write_protect_o || eeprom_read_protect_o))
    else $error("programmer eeprom write not blocked");
  AST_TBL_ACK: assert property (
    s_tbl_req |=> tbl_ack_o)
    else $error("table access not acknowledged");
  AST_CFG_BIT7: assert property (
    s_cfg_rd |=> !tbl_rdata_o[7])
    else $error("unused config bit reads one");
  AST_CWP_HOLD: assert property (
    $changed(config_write_protect_o) |-> $past(pgm_mode_i))
    else $error("config protect changed by running code");
endmodule : cfp_top_chk

bind cfp_top cfp_top_chk u_chk (.sys_clk_i, .reset_n_i, .pgm_mode_i,
  .tbl_addr_i, .table_read_instr_i, .table_write_instr_i, .cpu_ee_rd_i,
  .cpu_ee_wr_i, .tbl_rdata_o, .tbl_ack_o, .cpu_ee_rd_o, .cpu_ee_wr_o,
  .ext_ee_rd_o, .ext_ee_wr_o, .monitor_power_level_o,
  .zero_power_undervoltage_monitor_o, .trip_voltage_select_o,
  .trip_voltage_mv_o, .startup_timer_en_o, .eeprom_read_protect_o,
  .eeprom_write_protect_o, .config_write_protect_o);

/* bench/cfp_prog_model.sv */
module cfp_prog_model
  import cfp_pkg::*;
(
  // Programmer side of the link
  output logic pgm_clk_o,
  output logic pgm_mode_o,
  output logic line_o,
  // Device side of the data line
  input wire logic dev_d_i,
  input wire logic dev_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // Link
  // --------
  logic host_oe;
  logic host_d;
  logic last;

  // clock and data
  // A released line shows the inverse of the last bit, so stale data
  // can never pass for a reply.
  assign line_o = dev_oe_i ? dev_d_i : (host_oe ? host_d : ~last);

  initial
  begin
    pgm_clk_o = 1'b0;
    pgm_mode_o = 1'b0;
    host_oe = 1'b0;
    host_d = 1'b0;
    last = 1'b0;
  end

  task automatic set_mode(input logic m);
    pgm_mode_o = m;
  endtask : set_mode

  task automatic frame(input cfp_frame_type cmd, output logic [7:0] rep);
    for (int k = 0; k < 40; k++)
    begin
      pgm_clk_o = 1'b0;
      #12;
      host_oe = (k >= 8);
      if (k >= 8)
        host_d = cmd[39 - k];
      #12;
      if (k < 8)
        rep[7 - k] = line_o;
      last = line_o;
      pgm_clk_o = 1'b1;
      #24;
    end
    pgm_clk_o = 1'b0;
    #24;
    host_oe = 1'b0;
  endtask : frame
endmodule : cfp_prog_model

/* bench/config_fuse_protection_tb_top.sv */
module config_fuse_protection_tb_top;
  import cfp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // Bench
  // --------
  localparam logic [11:0] MV [4] = '{CFP_TRIP_MV_0, CFP_TRIP_MV_1,
    CFP_TRIP_MV_2, CFP_TRIP_MV_3};
  logic sys_clk_i, reset_n_i, pgm_clk_i, pgm_mode_i, pgm_data_i;
  logic pgm_data_o, pgm_data_oe_o, table_read_instr_i, table_write_instr_i;
  logic [21:0] tbl_addr_i;
  logic [7:0] tbl_wdata_i, tbl_rdata_o, ext_ee_rdata_i, ext_ee_wdata_o;
  logic tbl_ack_o, cpu_ee_rd_i, cpu_ee_wr_i, cpu_ee_rd_o, cpu_ee_wr_o;
  logic [9:0] ext_ee_addr_o, ee_addr_seen;
  logic ext_ee_rd_o, ext_ee_wr_o, soft_undervoltage_enable_i, sleep_i;
  logic [1:0] monitor_power_level_o, trip_voltage_select_o;
  logic zero_power_undervoltage_monitor_o, undervoltage_reset_en_o;
  logic [11:0] trip_voltage_mv_o;
  logic [7:0] wd_seen;
  logic startup_timer_en_o, eeprom_read_protect_o, eeprom_write_protect_o;
  logic config_write_protect_o;
  int errors, checks_done, n_rd, n_wr;

  cfp_top dut (.sys_clk_i, .reset_n_i, .pgm_clk_i, .pgm_mode_i,
    .pgm_data_i, .pgm_data_o, .pgm_data_oe_o, .tbl_addr_i,
    .table_read_instr_i, .table_write_instr_i, .tbl_wdata_i, .tbl_rdata_o,
    .tbl_ack_o, .cpu_ee_rd_i, .cpu_ee_wr_i, .cpu_ee_rd_o, .cpu_ee_wr_o,
    .ext_ee_rdata_i, .ext_ee_addr_o, .ext_ee_wdata_o, .ext_ee_rd_o,
    .ext_ee_wr_o, .soft_undervoltage_enable_i, .sleep_i,
    .monitor_power_level_o, .zero_power_undervoltage_monitor_o,
    .trip_voltage_select_o, .trip_voltage_mv_o, .undervoltage_reset_en_o,
    .startup_timer_en_o, .eeprom_read_protect_o, .eeprom_write_protect_o,
    .config_write_protect_o);
  cfp_prog_model prog (.pgm_clk_o(pgm_clk_i), .pgm_mode_o(pgm_mode_i),
    .line_o(pgm_data_i), .dev_d_i(pgm_data_o), .dev_oe_i(pgm_data_oe_o));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Strobes are counted mid-cycle, away from the edge that moves them.
  always @(negedge sys_clk_i)
  begin
    n_rd += ext_ee_rd_o;
    n_wr += ext_ee_wr_o;
    if (ext_ee_rd_o === 1'b1)
      ee_addr_seen = ext_ee_addr_o;
    if (ext_ee_wr_o === 1'b1)
      wd_seen = ext_ee_wdata_o;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic do_reset;
    reset_n_i = 1'b0;
    tick(12);
    reset_n_i = 1'b1;
    tick(3);
  endtask : do_reset

  task automatic tbl(input logic w, input logic [21:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_i);
    #1;
    tbl_addr_i = a;
    tbl_wdata_i = d;
    table_read_instr_i = !w;
    table_write_instr_i = w;
    tick(1);
    table_read_instr_i = 1'b0;
    table_write_instr_i = 1'b0;
    chk(tbl_ack_o, 1'b1);
    q = tbl_rdata_o;
  endtask : tbl

  task automatic frm(input cfp_op_type op, input logic [21:0] a,
    input logic [7:0] d, output logic [7:0] r);
    prog.frame({op, a, d}, r);
    tick(12);
  endtask : frm

  task automatic t_modes;
    logic [7:0] q;
    logic [1:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      tbl(1'b1, CFP_CFG_ADDR, {1'b1, m, m, m, m[0]}, q);
      tbl(1'b0, CFP_CFG_ADDR, 8'h00, q);
      chk(q, {1'b0, m, m, m, m[0]});
      do_reset;
      chk(monitor_power_level_o, m);
      chk(zero_power_undervoltage_monitor_o, m == 2'h3);
      chk(trip_voltage_select_o, m);
      chk(trip_voltage_mv_o, MV[m]);
      for (int s = 0; s < 4; s++)
      begin
        soft_undervoltage_enable_i = s[0];
        sleep_i = s[1];
        tick(3);
        chk(undervoltage_reset_en_o, m == 2'h3 || (m == 2'h2 && !s[1])
          || (m == 2'h1 && s[0]));
        chk(startup_timer_en_o, !m[0]);
      end
    end
  endtask : t_modes

  task automatic t_prot;
    logic [7:0] q;
    tbl(1'b1, CFP_PROT_ADDR, 8'h07, q);
    tbl(1'b0, CFP_PROT_ADDR, 8'h00, q);
    chk(q, 8'h03);
    cpu_ee_rd_i = 1'b1;
    cpu_ee_wr_i = 1'b1;
    #1;
    chk({cpu_ee_rd_o, cpu_ee_wr_o, config_write_protect_o}, 3'h4);
    tbl(1'b1, CFP_PROT_ADDR, 8'h00, q);
    tick(1);
    chk({cpu_ee_rd_o, cpu_ee_wr_o}, 2'h3);
    cpu_ee_rd_i = 1'b0;
    cpu_ee_wr_i = 1'b0;
  endtask : t_prot

  task automatic t_link;
    logic [7:0] r;
    int b;
    prog.set_mode(1'b1);
    tick(4);
    frm(OP_WRITE, CFP_PROT_ADDR, 8'h04, r);
    chk(config_write_protect_o, 1'b1);
    tbl(1'b1, CFP_CFG_ADDR, 8'h00, r);
    tbl(1'b1, CFP_PROT_ADDR, 8'h00, r);
    tbl(1'b0, CFP_CFG_ADDR, 8'h00, r);
    chk({r, config_write_protect_o}, 9'h0FF);
    b = n_rd;
    frm(OP_READ, CFP_EE_BASE + 22'h5, 8'h00, r);
    chk({6'(n_rd - b), ee_addr_seen}, {6'h1, 10'h5});
    frm(OP_WRITE, CFP_PROT_ADDR, 8'h05, r);
    chk(r, 8'hA5);
    b = n_rd + n_wr;
    frm(OP_READ, CFP_EE_BASE + 22'h5, 8'h00, r);
    frm(OP_WRITE, CFP_EE_BASE + 22'h6, 8'h3C, r);
    chk({r, 8'(n_rd + n_wr - b)}, 16'h0);
    frm(OP_WRITE, CFP_PROT_ADDR, 8'h06, r);
    b = n_wr;
    frm(OP_WRITE, CFP_EE_BASE + 22'h6, 8'h3C, r);
    chk(n_wr - b, 0);
    frm(OP_WRITE, CFP_PROT_ADDR, 8'h04, r);
    frm(OP_WRITE, CFP_EE_BASE + 22'h6, 8'h3C, r);
    chk({8'(n_wr - b), wd_seen}, 16'h013C);
  endtask : t_link

  task automatic t_ids;
    logic [7:0] q;
    for (int i = 0; i < CFP_ID_COUNT; i++)
      tbl(1'b1, CFP_ID_BASE + 22'(i), 8'hC0 + 8'(i), q);
    frm(OP_WRITE, CFP_PROT_ADDR, 8'h07, q);
    for (int i = 0; i < CFP_ID_COUNT; i++)
    begin
      tbl(1'b0, CFP_ID_BASE + 22'(i), 8'h00, q);
      chk(q, 8'hC0 + 8'(i));
    end
    frm(OP_READ, CFP_ID_BASE + 22'h7, 8'h00, q);
    frm(OP_IDLE_A, 22'h0, 8'h00, q);
    chk(q, 8'hC7);
    frm(OP_IDLE_B, 22'h0, 8'h00, q);
    tbl(1'b0, 22'h0, 8'h00, q);
    chk(q, 8'h00);
  endtask : t_ids

  task automatic stop_test;
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // The whole run needs well under a tenth of this span.
  initial
  begin
    #2000000;
    errors++;
    stop_test;
  end

  initial
  begin
    reset_n_i = 1'b0;
    tbl_addr_i = 22'h0;
    tbl_wdata_i = 8'h00;
    table_read_instr_i = 1'b0;
    table_write_instr_i = 1'b0;
    cpu_ee_rd_i = 1'b0;
    cpu_ee_wr_i = 1'b0;
    ext_ee_rdata_i = 8'hA5;
    soft_undervoltage_enable_i = 1'b0;
    sleep_i = 1'b0;
    do_reset;
    t_modes;
    t_prot;
    t_link;
    t_ids;
    stop_test;
  end
endmodule : config_fuse_protection_tb_top
